// File: bench/lapd_link_context_fields_tb.sv
`timescale 1ns/1ps
module lapd_link_context_fields_tb
  import lcf_pkg::*;
;
  // --------------------------------
  // Signals
  // --------------------------------
  localparam int PRE = 4;
  localparam int P_KEEP = 0, P_DISC = 1, P_GOOD = 2, P_NEXT = 3, P_EACC = 4, P_REJ = 5;
  localparam int P_NEG = 6, P_OK = 7, P_REF = 8, P_EXP = 9;
  logic clock = 1'b0;
  logic rst = 1'b1;
  lcf_bus_req_t bus;
  logic [15:0] rdata;
  lcf_link_evt_t ev = '0;
  lcf_rx_evt_t rx = '0;
  logic np = 1'b0;
  logic mb = 1'b0;
  logic [7:0] pmask = 8'h01;
  logic [7:0] npmask = 8'h02;
  logic txl = 1'b0;
  logic [15:0] txlen = 16'h0000;
  logic [3:0] link_state;
  logic [1:0] qsel;
  logic run, expd, rej, uok, uneg, sref, keep, lng, disc, good, bnext, eacc;
  logic [12:0] pidx;
  logic [15:0] tx_len;
  logic [15:0] d;
  logic [9:0] pv;
  int cnt [10];
  int err_count = 0;
  int samples_checked = 0;

  always #50 clock = ~clock;
  assign pv = {expd, sref, uok, uneg, rej, eacc, bnext, good, disc, keep};

  lcf_link_context #(.PRESCALE_CYCLES(PRE)) dut (
    .clock(clock), .rst(rst), .bus(bus), .ev(ev), .rx(rx), .nonprotocol_mode(np),
    .multibuffer_mode(mb), .protocol_error_mask(pmask), .nonprotocol_error_mask(npmask),
    .tx_desc_load(txl), .tx_desc_len(txlen), .rdata(rdata), .link_state(link_state),
    .tx_queue_sel(qsel), .t200_running(run), .t200_expired(expd), .rej_request(rej),
    .ui_accept(uok), .ui_neg_confirm(uneg), .state_refused(sref), .rx_pool_index(pidx),
    .rx_byte_keep(keep), .rx_long_frame(lng), .rx_frame_discard(disc),
    .rx_frame_good(good), .rx_buf_next(bnext), .rx_errored_accept(eacc), .tx_len(tx_len)
  );

  lcf_host_model host (.clock(clock), .rdata(rdata), .bus(bus));

  // Pulses counted at the edge after they rise
  always @(posedge clock)
  begin
    foreach (cnt[i])
    begin
      if (pv[i] === 1'b1)
        cnt[i]++;
    end
  end

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input int e, input logic [15:0] g);
    samples_checked++;
    if (g !== 16'(e))
    begin
      $display("mismatch %s expected %h seen %h", what, 16'(e), g);
      err_count++;
    end
  endtask

  task automatic pulse_ev(input lcf_link_evt_t e);
    @(negedge clock);
    cnt = '{default: 0};
    @(posedge clock);
    ev <= e;
    @(posedge clock);
    ev <= '0;
    @(posedge clock);
    @(negedge clock);
  endtask

  task automatic st(input logic [3:0] v);
    pulse_ev(lcf_link_evt_t'{state_wr: 1'b1, state_val: v, default: '0});
  endtask

  task automatic stat(input lcf_link_evt_t e, input int x);
    pulse_ev(e);
    host.rd(OFF_STATUS, d);
    chk("status", x, d);
  endtask

  task automatic rxf(input int nb, input logic inf, input logic num, input logic er,
                     input logic [7:0] cls, input int k, input int g, input int l,
                     input int bn, input int ea);
    @(negedge clock);
    cnt = '{default: 0};
    @(posedge clock);
    rx <= lcf_rx_evt_t'{start: 1'b1, default: '0};
    repeat (nb)
    begin
      @(posedge clock);
      rx <= lcf_rx_evt_t'{byte_valid: 1'b1, is_info: inf, default: '0};
    end
    @(posedge clock);
    rx <= lcf_rx_evt_t'{end_flag: 1'b1, numbered: num, errored: er, err_class: cls,
                        default: '0};
    @(posedge clock);
    rx <= '0;
    @(posedge clock);
    @(negedge clock);
    chk("kept bytes", k, 16'(cnt[P_KEEP]));
    chk("long flag", l, 16'(lng));
    chk("next buffer", bn, 16'(cnt[P_NEXT]));
    chk("errored accept", ea, 16'(cnt[P_EACC]));
    if (g >= 0)
    begin
      chk("frame good", g, 16'(cnt[P_GOOD]));
      chk("frame discard", 1 - g, 16'(cnt[P_DISC]));
    end
  endtask

  task automatic wait_exp(input time ts, input int k);
    int i;
    for (i = 0; i < 100; i++)
    begin
      if (expd === 1'b1)
        break;
      @(negedge clock);
    end
    if (i == 100)
    begin
      $display("mismatch timer expiry expected %0d seen none", k);
      err_count++;
      finish_test;
    end
    chk("timer cycles", k, 16'((($time - ts) - 50) / 100));
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic test_regs;
    int q;
    for (q = 0; q < 5; q++)
    begin
      host.rd(3'(q), d);
      chk("reset value", 0, d);
    end
    host.wr(OFF_STATUS, 16'h0038);
    host.rd(OFF_STATUS, d);
    chk("status", 16'h0008, d);
    host.wr(OFF_STATUS, 16'h0000);
    host.wr(OFF_SIZE, 16'hffff);
    host.wr(OFF_POOL, 16'hffff);
    host.wr(OFF_T200, 16'h01ff);
    host.wr(3'h5, 16'hffff);
    host.rd(OFF_SIZE, d);
    chk("size", 16'h7fff, d);
    host.rd(OFF_POOL, d);
    chk("pool", 16'h9fff, d);
    chk("pool index", 16'h1fff, 16'(pidx));
    host.rd(OFF_T200, d);
    chk("reload", 16'h01ff, d);
    host.rd(3'h5, d);
    chk("unmapped", 0, d);
    for (q = 0; q < 4; q++)
    begin
      // Written at any time; only bits 10-9 are stored
      host.wr(OFF_QUEUE, 16'hf9ff | 16'(q << 9));
      host.rd(OFF_QUEUE, d);
      chk("queue", q << 9, d);
      chk("queue select", q, 16'(qsel));
    end
    $display("test registers done");
  endtask

  task automatic test_flags;
    stat(lcf_link_evt_t'{xid_cmd_sent: 1'b1, default: '0}, 16'h0400);
    stat(lcf_link_evt_t'{xid_resp_rcvd: 1'b1, default: '0}, 16'h0000);
    stat(lcf_link_evt_t'{t203_poll_sent: 1'b1, default: '0}, 16'h0300);
    stat(lcf_link_evt_t'{inquiry_resp_rcvd: 1'b1, default: '0}, 16'h0100);
    stat(lcf_link_evt_t'{final_rcvd: 1'b1, default: '0}, 16'h0000);
    stat(lcf_link_evt_t'{poll_cmd_sent: 1'b1, default: '0}, 16'h0100);
    stat(lcf_link_evt_t'{final_rcvd: 1'b1, default: '0}, 16'h0000);
    $display("test flags done");
  endtask

  task automatic test_states;
    int v;
    logic [3:0] cur;
    logic ok;
    cur = link_state;
    for (v = 0; v < 16; v++)
    begin
      ok = v inside {1, 3, 4, 5, 6, 8, 9, 10, 12, 13, 14};
      st(4'(v));
      if (ok)
        cur = 4'(v);
      chk("link state", 16'(cur), 16'(link_state));
      chk("state refused", 16'(!ok), 16'(cnt[P_REF]));
    end
    $display("test states done");
  endtask

  task automatic test_busy;
    st(4'b1110);
    stat(lcf_link_evt_t'{i_discarded: 1'b1, default: '0}, 16'h001e);
    stat(lcf_link_evt_t'{rej_sent: 1'b1, default: '0}, 16'h002e);
    st(4'b1100);
    chk("reject request", 0, 16'(cnt[P_REJ]));
    st(4'b1010);
    stat(lcf_link_evt_t'{i_discarded: 1'b1, default: '0}, 16'h001a);
    st(4'b1000);
    chk("reject request", 1, 16'(cnt[P_REJ]));
    stat(lcf_link_evt_t'{i_discarded: 1'b1, default: '0}, 16'h0028);
    $display("test busy reject done");
  endtask

  task automatic test_ui;
    st(4'b0001);
    pulse_ev(lcf_link_evt_t'{ui_req: 1'b1, default: '0});
    chk("negative confirm", 1, 16'(cnt[P_NEG]));
    chk("ui accept", 0, 16'(cnt[P_OK]));
    chk("link state", 1, 16'(link_state));
    st(4'b0100);
    pulse_ev(lcf_link_evt_t'{ui_req: 1'b1, default: '0});
    chk("ui accept", 1, 16'(cnt[P_OK]));
    chk("negative confirm", 0, 16'(cnt[P_NEG]));
    $display("test unnumbered done");
  endtask

  task automatic test_timer;
    time ts;
    host.wr(OFF_T200, 16'h0002);
    pulse_ev(lcf_link_evt_t'{t200_start: 1'b1, default: '0});
    ts = $time - 150;
    chk("running", 1, 16'(run));
    host.wr(OFF_T200, 16'h0005);
    wait_exp(ts, 2 * PRE);
    chk("running", 0, 16'(run));
    pulse_ev(lcf_link_evt_t'{t200_start: 1'b1, default: '0});
    ts = $time - 150;
    wait_exp(ts, 5 * PRE);
    pulse_ev(lcf_link_evt_t'{t200_start: 1'b1, default: '0});
    pulse_ev(lcf_link_evt_t'{t200_stop: 1'b1, default: '0});
    chk("running", 0, 16'(run));
    repeat (25) @(posedge clock);
    @(negedge clock);
    chk("stopped expiry", 0, 16'(cnt[P_EXP]));
    $display("test timer done");
  endtask

  task automatic test_rx;
    host.wr(OFF_SIZE, 16'h0003);
    host.wr(OFF_POOL, 16'h8005);
    rxf(5, 0, 0, 0, 8'h00, 5, 1, 0, 0, 0);
    rxf(4, 0, 0, 0, 8'h00, 4, 0, 0, 0, 0);
    rxf(5, 0, 1, 0, 8'h00, 5, 0, 0, 0, 0);
    rxf(6, 0, 1, 0, 8'h00, 6, 1, 0, 0, 0);
    rxf(5, 1, 0, 0, 8'h00, 3, -1, 1, 0, 0);
    rxf(5, 0, 0, 1, 8'h01, 5, 1, 0, 0, 1);
    rxf(5, 0, 0, 1, 8'h02, 5, 0, 0, 0, 0);
    host.wr(OFF_POOL, 16'h0005);
    chk("pool index", 5, 16'(pidx));
    rxf(6, 0, 0, 1, 8'h01, 6, 0, 0, 0, 0);
    host.wr(OFF_SIZE, 16'h0000);
    rxf(5, 1, 0, 0, 8'h00, 0, -1, 1, 0, 0);
    @(posedge clock);
    np <= 1'b1;
    host.wr(OFF_SIZE, 16'h0006);
    host.wr(OFF_POOL, 16'h8005);
    rxf(8, 0, 0, 0, 8'h00, 6, -1, 1, 0, 0);
    rxf(5, 0, 0, 0, 8'h00, 5, 1, 0, 0, 0);
    rxf(4, 0, 0, 0, 8'h00, 4, 0, 0, 0, 0);
    rxf(5, 0, 0, 1, 8'h02, 5, 1, 0, 0, 1);
    rxf(5, 0, 0, 1, 8'h01, 5, 0, 0, 0, 0);
    @(posedge clock);
    mb <= 1'b1;
    rxf(11, 0, 0, 0, 8'h00, 11, -1, 0, 2, 0);
    @(posedge clock);
    txl <= 1'b1;
    txlen <= 16'h7fff;
    @(posedge clock);
    txl <= 1'b0;
    @(negedge clock);
    chk("transmit length", 16'h7fff, tx_len);
    $display("test receive and transmit length done");
  endtask

  initial
  begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    test_regs();
    test_flags();
    test_states();
    test_busy();
    test_ui();
    test_timer();
    test_rx();
    finish_test();
  end
endmodule

// File: bench/lcf_host_model.sv
`timescale 1ns/1ps
// --------------------------------
// Host software on the register port
// --------------------------------
module lcf_host_model
  import lcf_pkg::*;
(
  input wire logic clock,
  input wire logic [15:0] rdata,
  output lcf_bus_req_t bus
);
  initial bus = '0;

  // Strobe dropped at the next edge; the next call waits one edge more,
  // so no field is assigned twice in one time step
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clock);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge clock);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    @(negedge clock);
    v = rdata;
  endtask
endmodule

// File: design/lcf_link_context.sv
`timescale 1ns/1ps
// Functional notes
// - Bit 10 set after identification command, awaiting reply
// - Bit 9 set on T203 poll supervisory
// - Bit 8 set after poll command, awaiting final
// - Busy-reject field: none, owed, sent; never 11
// - Leaving busy state sends reject only if owed
// - Link state bits 3-0 use defined encodings
// - Undefined state codes refused from the engine; host status writes store any code
// - Unnumbered request while unassigned: negative confirm
// - Bits 10-9 select one of four queues
// - Nine-bit reload latched at next timer start
// - Each timer count is 2^20 clocks
// - Fifteen-bit size limit, zero blocks data except in multi buffer mode
// - Protocol: info limit, minimum 5 or 6
// - Single buffer: limit per buffer, minimum 5
// - Multi buffer: limit minus two, extra buffers
// - Short frames dropped, long frames flagged, truncated
// - Transmit length taken as given, unchecked
// - Thirteen-bit pool number indexes pool table
// - Errored frames accepted only with mask bit
module lcf_link_context
  import lcf_pkg::*;
#(
  parameter int unsigned PRESCALE_CYCLES = T200_UNIT_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire lcf_bus_req_t bus,
  input wire lcf_link_evt_t ev,
  input wire lcf_rx_evt_t rx,
  input wire logic nonprotocol_mode,
  input wire logic multibuffer_mode,
  input wire logic [7:0] protocol_error_mask,
  input wire logic [7:0] nonprotocol_error_mask,
  input wire logic tx_desc_load,
  input wire logic [15:0] tx_desc_len,
  output logic [15:0] rdata,
  output logic [3:0] link_state,
  output logic [1:0] tx_queue_sel,
  output logic t200_running,
  output logic t200_expired,
  output logic rej_request,
  output logic ui_accept,
  output logic ui_neg_confirm,
  output logic state_refused,
  output logic [12:0] rx_pool_index,
  output logic rx_byte_keep,
  output logic rx_long_frame,
  output logic rx_frame_discard,
  output logic rx_frame_good,
  output logic rx_buf_next,
  output logic rx_errored_accept,
  output logic [15:0] tx_len
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic state_defined(input logic [3:0] v);
    case (v)
      LS_ID_UNASSIGNED, LS_EST_AWAIT_ID, LS_ID_ASSIGNED, LS_AWAIT_EST,
      LS_AWAIT_REL, LS_MF_NORMAL, LS_MF_REJECT, LS_MF_BUSY,
      LS_TR_NORMAL, LS_TR_REJECT, LS_TR_BUSY: state_defined = 1'b1;
      default: state_defined = 1'b0;
    endcase
  endfunction

  function automatic logic state_busy(input logic [3:0] v);
    state_busy = (v == LS_MF_BUSY) || (v == LS_TR_BUSY);
  endfunction

  function automatic logic [15:0] status_word(input lcf_state_t s);
    status_word = {2'b00, s.upper, s.xid, s.inq, s.poll, 2'b00, s.br, s.lstate};
  endfunction

  function automatic logic [15:0] reg_read(input logic [2:0] a, input lcf_state_t s);
    case (a)
      OFF_STATUS: reg_read = status_word(s);
      OFF_QUEUE: reg_read = {5'h00, s.qsel, 9'h000};
      OFF_T200: reg_read = {7'h00, s.t200_reload};
      OFF_SIZE: reg_read = {1'b0, s.size_lim};
      OFF_POOL: reg_read = {s.errored_accept_bit, 2'b00, s.pool};
      default: reg_read = 16'h0000;
    endcase
  endfunction

  lcf_state_t st;
  lcf_state_t next_st;
  logic [15:0] next_min;
  logic [7:0] next_mask;
  logic next_leave_busy;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.rdata = 16'h0000;
    next_st.t200_exp = 1'b0;
    next_st.rej_req = 1'b0;
    next_st.ui_neg = 1'b0;
    next_st.ui_ok = 1'b0;
    next_st.st_refused = 1'b0;
    next_st.rx_keep = 1'b0;
    next_st.rx_disc = 1'b0;
    next_st.rx_good = 1'b0;
    next_st.rx_buf_next = 1'b0;
    next_st.rx_err_acc = 1'b0;
    next_min = MIN_FRAME_UNNUM;
    next_mask = 8'h00;
    next_leave_busy = 1'b0;

    if (bus.rd)
      next_st.rdata = reg_read(bus.addr, st);

    // Host writes first; device events below override the same bits
    if (bus.wr)
    begin
      case (bus.addr)
        OFF_STATUS:
        begin
          next_st.upper = bus.wdata[UPPER_LO +: 3];
          next_st.xid = bus.wdata[XID_BIT];
          next_st.inq = bus.wdata[INQ_BIT];
          next_st.poll = bus.wdata[POLL_BIT];
          next_st.br = (bus.wdata[BR_LO +: 2] == 2'b11) ? BR_NONE : bus.wdata[BR_LO +: 2];
          next_st.lstate = bus.wdata[3:0];
        end
        OFF_QUEUE: next_st.qsel = bus.wdata[QSEL_LO +: 2];
        OFF_T200: next_st.t200_reload = bus.wdata[8:0];
        OFF_SIZE: next_st.size_lim = bus.wdata[14:0];
        OFF_POOL:
        begin
          next_st.pool = bus.wdata[12:0];
          next_st.errored_accept_bit = bus.wdata[EMV_BIT];
        end
        default: next_st.rdata = next_st.rdata;
      endcase
    end

    // Pending-response flags: set wins over clear
    if (ev.xid_resp_rcvd)
      next_st.xid = 1'b0;
    if (ev.xid_cmd_sent)
      next_st.xid = 1'b1;
    if (ev.inquiry_resp_rcvd)
      next_st.inq = 1'b0;
    if (ev.t203_poll_sent)
      next_st.inq = 1'b1;
    if (ev.final_rcvd)
      next_st.poll = 1'b0;
    if (ev.poll_cmd_sent || ev.t203_poll_sent)
      next_st.poll = 1'b1;

    // Link state updates from the protocol engine
    if (ev.state_wr)
    begin
      if (state_defined(ev.state_val))
      begin
        next_st.lstate = ev.state_val;
        next_leave_busy = state_busy(st.lstate) && !state_busy(ev.state_val);
      end
      else
        next_st.st_refused = 1'b1;
    end

    // Busy-reject tracking
    if (ev.i_discarded && state_busy(st.lstate) && st.br == BR_NONE)
      next_st.br = BR_OWED;
    if (ev.rej_sent)
      next_st.br = BR_SENT;
    if (next_leave_busy)
    begin
      next_st.rej_req = (st.br == BR_OWED);
      next_st.br = (st.br == BR_OWED) ? BR_SENT : BR_NONE;
    end

    // Unnumbered-information request; nothing is stored either way
    if (ev.ui_req)
    begin
      if (st.lstate == LS_ID_UNASSIGNED)
        next_st.ui_neg = 1'b1;
      else
        next_st.ui_ok = 1'b1;
    end

    // Acknowledgement timer: reload sampled only at start
    if (ev.t200_start)
    begin
      next_st.t200_val = st.t200_reload;
      next_st.t200_cnt = st.t200_reload;
      next_st.prescale = 20'h00000;
      next_st.t200_run = (st.t200_reload != 9'h000);
      next_st.t200_exp = (st.t200_reload == 9'h000);
    end
    else if (ev.t200_stop)
      next_st.t200_run = 1'b0;
    else if (st.t200_run)
    begin
      if (st.prescale == 20'(PRESCALE_CYCLES - 1))
      begin
        next_st.prescale = 20'h00000;
        if (st.t200_cnt == 9'h001)
        begin
          next_st.t200_exp = 1'b1;
          next_st.t200_run = 1'b0;
        end
        next_st.t200_cnt = st.t200_cnt - 9'h001;
      end
      else
        next_st.prescale = st.prescale + 20'h00001;
    end

    // Receive length checks
    if (nonprotocol_mode || !rx.numbered)
      next_min = MIN_FRAME_UNNUM;
    else
      next_min = MIN_FRAME_NUM;
    next_mask = nonprotocol_mode ? nonprotocol_error_mask : protocol_error_mask;

    if (rx.start)
    begin
      next_st.rx_cnt = 16'h0000;
      next_st.dcnt = 16'h0000;
      next_st.rx_long = 1'b0;
    end
    else if (rx.byte_valid)
    begin
      if (st.rx_cnt != 16'hffff)
        next_st.rx_cnt = st.rx_cnt + 16'h0001;
      if (!nonprotocol_mode)
      begin
        if (!rx.is_info)
          next_st.rx_keep = 1'b1;
        else if (st.dcnt < {1'b0, st.size_lim})
        begin
          next_st.rx_keep = 1'b1;
          next_st.dcnt = st.dcnt + 16'h0001;
        end
        else
          next_st.rx_long = 1'b1;
      end
      else if (!multibuffer_mode)
      begin
        if (st.dcnt < {1'b0, st.size_lim})
        begin
          next_st.rx_keep = 1'b1;
          next_st.dcnt = st.dcnt + 16'h0001;
        end
        else
          next_st.rx_long = 1'b1;
      end
      else
      begin
        // The last two bytes of a full buffer move on with this one
        next_st.rx_keep = 1'b1;
        if (st.dcnt == {1'b0, st.size_lim})
        begin
          next_st.rx_buf_next = 1'b1;
          next_st.dcnt = MB_RESERVE + 16'h0001;
        end
        else
          next_st.dcnt = st.dcnt + 16'h0001;
      end
    end
    else if (rx.end_flag)
    begin
      if (st.rx_cnt < next_min)
        next_st.rx_disc = 1'b1;
      else if (rx.errored)
      begin
        if (st.errored_accept_bit && ((rx.err_class & next_mask) != 8'h00))
        begin
          next_st.rx_err_acc = 1'b1;
          next_st.rx_good = 1'b1;
        end
        else
          next_st.rx_disc = 1'b1;
      end
      else
        next_st.rx_good = 1'b1;
    end

    if (tx_desc_load)
      next_st.tx_len = tx_desc_len;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign rdata = st.rdata;
  assign link_state = st.lstate;
  assign tx_queue_sel = st.qsel;
  assign t200_running = st.t200_run;
  assign t200_expired = st.t200_exp;
  assign rej_request = st.rej_req;
  assign ui_accept = st.ui_ok;
  assign ui_neg_confirm = st.ui_neg;
  assign state_refused = st.st_refused;
  assign rx_pool_index = st.pool;
  assign rx_byte_keep = st.rx_keep;
  assign rx_long_frame = st.rx_long;
  assign rx_frame_discard = st.rx_disc;
  assign rx_frame_good = st.rx_good;
  assign rx_buf_next = st.rx_buf_next;
  assign rx_errored_accept = st.rx_err_acc;
  assign tx_len = st.tx_len;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [31:0] a_since;

  always_ff @(posedge clock or posedge rst)
  begin
    // Counts the running edges after the start edge, one per clock
    if (rst)
      a_since <= 32'h00000000;
    else if (ev.t200_start)
      a_since <= 32'h00000000;
    else if (st.t200_run)
      a_since <= a_since + 32'h00000001;
  end

  default clocking a_clk @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_busy_owed;
    state_busy(st.lstate) && st.br == BR_OWED && !ev.rej_sent;
  endsequence

  sequence s_leave_busy;
    ev.state_wr && state_defined(ev.state_val) && !state_busy(ev.state_val);
  endsequence

  a_xid_pending: assert property (ev.xid_cmd_sent |=> st.xid)
    else $error("identification flag not set");
  a_inquiry_pending: assert property (ev.t203_poll_sent |=> st.inq && st.poll)
    else $error("inquiry flag not set");
  a_poll_pending: assert property ((ev.poll_cmd_sent && !bus.wr) |=> st.poll)
    else $error("poll flag not set");
  a_br_valid: assert property (st.br != 2'b11)
    else $error("busy reject holds invalid code");
  a_rej_on_exit: assert property ((s_busy_owed and s_leave_busy) |=> rej_request && st.br == BR_SENT)
    else $error("owed reject not requested");
  a_no_rej_spur: assert property (!(st.br == BR_OWED) |=> !rej_request)
    else $error("reject requested without debt");
  a_state_legal: assert property (ev.state_wr && !state_defined(ev.state_val) && !bus.wr
    |=> $stable(st.lstate) && state_refused)
    else $error("undefined state written");
  a_ui_negative: assert property (ev.ui_req && st.lstate == LS_ID_UNASSIGNED
    && !ev.state_wr && !bus.wr |=> ui_neg_confirm && !ui_accept && $stable(st.lstate))
    else $error("unassigned request not refused");
  a_reload_held: assert property (st.t200_run && !ev.t200_start |=> $stable(st.t200_val))
    else $error("timer reload changed while running");
  a_timer_length: assert property (t200_expired && $past(st.t200_run)
    |-> a_since == st.t200_val * PRESCALE_CYCLES)
    else $error("timer length wrong");
  a_short_drop: assert property (rx.end_flag && !rx.start && !rx.byte_valid
    && st.rx_cnt < MIN_FRAME_UNNUM |=> rx_frame_discard && !rx_frame_good)
    else $error("short frame kept");
  a_limit_keep: assert property (rx.byte_valid && !rx.start && nonprotocol_mode
    && !multibuffer_mode && st.dcnt >= {1'b0, st.size_lim} |=> !rx_byte_keep && rx_long_frame)
    else $error("byte beyond limit kept");
  a_error_reject: assert property (rx.end_flag && !rx.start && !rx.byte_valid && rx.errored
    && !st.errored_accept_bit && st.rx_cnt >= MIN_FRAME_NUM |=> rx_frame_discard)
    else $error("errored frame accepted without mask bit");

endmodule

// File: design/lcf_pkg.sv
package lcf_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam logic [2:0] OFF_STATUS = 3'h0;
  localparam logic [2:0] OFF_QUEUE = 3'h1;
  localparam logic [2:0] OFF_T200 = 3'h2;
  localparam logic [2:0] OFF_SIZE = 3'h3;
  localparam logic [2:0] OFF_POOL = 3'h4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int XID_BIT = 10;
  localparam int INQ_BIT = 9;
  localparam int POLL_BIT = 8;
  localparam int UPPER_LO = 11;
  localparam int BR_LO = 4;
  localparam int QSEL_LO = 9;
  localparam int EMV_BIT = 15;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam int T200_UNIT_LOG2 = 20;
  localparam int unsigned T200_UNIT_CYCLES = 32'd1 << T200_UNIT_LOG2;
  localparam logic [15:0] MIN_FRAME_UNNUM = 16'h0005;
  localparam logic [15:0] MIN_FRAME_NUM = 16'h0006;
  localparam logic [15:0] MB_RESERVE = 16'h0002;

  typedef enum logic [3:0] {
    LS_UNINIT = 4'b0000,
    LS_ID_UNASSIGNED = 4'b0001,
    LS_EST_AWAIT_ID = 4'b0011,
    LS_ID_ASSIGNED = 4'b0100,
    LS_AWAIT_EST = 4'b0101,
    LS_AWAIT_REL = 4'b0110,
    LS_MF_NORMAL = 4'b1000,
    LS_MF_REJECT = 4'b1001,
    LS_MF_BUSY = 4'b1010,
    LS_TR_NORMAL = 4'b1100,
    LS_TR_REJECT = 4'b1101,
    LS_TR_BUSY = 4'b1110
  } lcf_link_state_t;

  typedef enum logic [1:0] {
    BR_NONE = 2'b00,
    BR_OWED = 2'b01,
    BR_SENT = 2'b10
  } lcf_busy_rej_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } lcf_bus_req_t;

  typedef struct packed {
    logic xid_cmd_sent;
    logic xid_resp_rcvd;
    logic t203_poll_sent;
    logic inquiry_resp_rcvd;
    logic poll_cmd_sent;
    logic final_rcvd;
    logic i_discarded;
    logic rej_sent;
    logic state_wr;
    logic [3:0] state_val;
    logic ui_req;
    logic t200_start;
    logic t200_stop;
  } lcf_link_evt_t;

  typedef struct packed {
    logic start;
    logic byte_valid;
    logic is_info;
    logic end_flag;
    logic numbered;
    logic errored;
    logic [7:0] err_class;
  } lcf_rx_evt_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic xid;
    logic inq;
    logic poll;
    logic [1:0] br;
    logic [3:0] lstate;
    logic [2:0] upper;
    logic [1:0] qsel;
    logic [8:0] t200_reload;
    logic [8:0] t200_val;
    logic [8:0] t200_cnt;
    logic [19:0] prescale;
    logic t200_run;
    logic t200_exp;
    logic [14:0] size_lim;
    logic [12:0] pool;
    logic errored_accept_bit;
    logic rej_req;
    logic ui_neg;
    logic ui_ok;
    logic st_refused;
    logic [15:0] rx_cnt;
    logic [15:0] dcnt;
    logic rx_keep;
    logic rx_long;
    logic rx_disc;
    logic rx_good;
    logic rx_buf_next;
    logic rx_err_acc;
    logic [15:0] tx_len;
  } lcf_state_t;

endpackage
